//--- rtl/electrode_wear_stepper.sv
// Electrode-wear stepper: weld counter, tip-dress check, linear heat/current ramp.
// Assumes one weld_done pulse per delivered weld; APB master per AMBA APB.
`timescale 1ns/10ps
`include "stepper_cfg.svh"
module electrode_wear_stepper #(
  parameter int NS = `NUM_STEPS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic weld_done,
  input wire logic stepper_reset_in,
  output logic [6:0] first_weld_interval_heat,
  output logic [6:0] second_weld_interval_heat,
  output logic [13:0] first_weld_interval_current,
  output logic [13:0] second_weld_interval_current,
  output logic dress_due_error,
  output logic step_end,
  output logic irq
);
  typedef struct packed {
    logic en;
    logic cc;
    stepper_pkg::count_t thr;
    stepper_pkg::count_t welds;
    logic [3:0] idx;
    stepper_pkg::count_t n;
    logic fin;
    stepper_pkg::heat_t base_h;
    stepper_pkg::count_t base_c;
    stepper_pkg::heat_t sb_h;
    stepper_pkg::count_t sb_c;
    logic neg_h;
    logic neg_c;
    stepper_pkg::heat_t heat;
    stepper_pkg::count_t cur;
    stepper_pkg::heat_t out_h;
    stepper_pkg::count_t out_c;
    logic pend;
    logic go;
    logic dress;
    logic [1:0] sts;
    logic [1:0] ie;
    logic [NS-1:0][13:0] scnt;
    logic [NS-1:0][6:0] sh;
    logic [NS-1:0][13:0] sc;
    logic [31:0] rdata;
    logic err;
  } regs_t;

  regs_t q, d;
  logic rst_meta, rst_s;
  logic wr, rd_setup, rst_req, tab_hit, div_done_h, div_done_c, busy_h;
  logic [3:0] tab_idx;
  logic [4:0] first_step, next_step;
  logic [7:0] tab_off;
  logic signed [7:0] dh;
  logic signed [14:0] dc;
  logic [27:0] num_h, num_c, quo_h, quo_c;
  logic [13:0] den;

  // ==========================================================
  // Reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_s <= rst_meta;
    end
  end

  // ==========================================================
  // Helpers
  // Lowest step at or above 'from' with a nonzero count; bit 4 flags found
  function automatic logic [4:0] find_step(input logic [NS-1:0][13:0] tab, input int from);
    logic [4:0] r;
    r = '0;
    for (int j = NS - 1; j >= 0; j--) begin
      if (j >= from && tab[j] != '0) begin
        r = {1'b1, 4'(j)};
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] clamp14(input logic [31:0] v, input logic [13:0] mx);
    return (v > {18'h0, mx}) ? mx : v[13:0];
  endfunction

  // ==========================================================
  // Bus decode
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign tab_off = paddr - `OFS_STEP_BASE;
  assign tab_idx = tab_off[7:4];
  assign tab_hit = (paddr >= `OFS_STEP_BASE) && (tab_off[7:4] < 4'(NS)) && (tab_off[3:2] != 2'h3);
  assign rst_req = stepper_reset_in || (wr && paddr == `OFS_CTRL && pwdata[`CTRL_RST_BIT]);
  assign first_step = find_step(q.scnt, 0);
  assign next_step = find_step(q.scnt, int'(q.idx) + 1);

  // ==========================================================
  // Ramp fraction: (target - base) * n / count
  assign dh = $signed({1'b0, q.sh[q.idx]}) - $signed({1'b0, q.base_h});
  assign dc = $signed({1'b0, q.sc[q.idx]}) - $signed({1'b0, q.base_c});
  assign num_h = 28'((dh < 0 ? -dh : dh)) * 28'(q.n);
  assign num_c = 28'((dc < 0 ? -dc : dc)) * 28'(q.n);
  assign den = (q.scnt[q.idx] == '0) ? 14'h0001 : q.scnt[q.idx];

  ramp_div #(.NW(28), .DW(14)) u_div_h (
    .mclk(mclk), .rst_n(rst_s), .start(q.go), .num(num_h), .den(den),
    .quo(quo_h), .busy(busy_h), .done(div_done_h)
  );
  ramp_div #(.NW(28), .DW(14)) u_div_c (
    .mclk(mclk), .rst_n(rst_s), .start(q.go), .num(num_c), .den(den),
    .quo(quo_c), .busy(), .done(div_done_c)
  );

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.go = 1'b0;
    if (wr) begin
      case (paddr)
        `OFS_CTRL: begin
          d.en = pwdata[`CTRL_EN_BIT];
          d.cc = pwdata[`CTRL_CC_BIT];
        end
        `OFS_DRESS: d.thr = clamp14(pwdata, `WELD_MAX);
        `OFS_CLEAR: d.sts = q.sts & ~pwdata[1:0];
        `OFS_IRQ_EN: d.ie = pwdata[1:0];
        default: begin
          if (tab_hit) begin
            case (tab_off[3:2])
              2'h0: d.scnt[tab_idx] = clamp14(pwdata, `WELD_MAX);
              2'h1: d.sh[tab_idx] = 7'(clamp14(pwdata, 14'(`HEAT_MAX)));
              default: d.sc[tab_idx] = clamp14(pwdata, `CUR_MAX);
            endcase
            d.pend = 1'b1;
          end
        end
      endcase
    end
    if (rst_req) begin
      d.welds = '0;
      d.n = '0;
      d.base_h = '0;
      d.base_c = '0;
      d.idx = first_step[3:0];
      d.fin = !first_step[4];
      d.pend = 1'b1;
    end else if (weld_done) begin
      if (q.welds != `WELD_MAX) begin
        d.welds = q.welds + 1'b1;
      end
      if (q.en && !q.fin) begin
        if (q.n + 1'b1 == q.scnt[q.idx]) begin
          d.base_h = q.sh[q.idx];
          d.base_c = q.sc[q.idx];
          d.n = '0;
          if (next_step[4]) begin
            d.idx = next_step[3:0];
          end else begin
            d.fin = 1'b1;
          end
        end else begin
          d.n = q.n + 1'b1;
        end
        d.pend = 1'b1;
      end
    end
    // Snapshot base and sign so a late result matches its own operands
    if (q.pend && !busy_h && !q.go) begin
      d.go = 1'b1;
      d.pend = 1'b0;
      d.sb_h = q.base_h;
      d.sb_c = q.base_c;
      d.neg_h = dh < 0;
      d.neg_c = dc < 0;
    end
    if (div_done_h) begin
      d.heat = q.neg_h ? q.sb_h - quo_h[6:0] : q.sb_h + quo_h[6:0];
    end
    if (div_done_c) begin
      d.cur = q.neg_c ? q.sb_c - quo_c[13:0] : q.sb_c + quo_c[13:0];
    end
    d.out_h = (q.en && !q.cc) ? q.heat : '0;
    d.out_c = (q.en && q.cc) ? q.cur : '0;
    d.dress = (d.welds == d.thr);
    // A new event beats a clear in the same cycle
    if (d.dress && !q.dress) begin
      d.sts[`STS_DRESS_BIT] = 1'b1;
    end
    if (d.fin && !q.fin) begin
      d.sts[`STS_STEP_END_BIT] = 1'b1;
    end
    if (rd_setup) begin
      d.err = 1'b0;
      case (paddr)
        `OFS_CTRL: d.rdata = {30'h0, q.cc, q.en};
        `OFS_DRESS: d.rdata = {18'h0, q.thr};
        `OFS_COUNT: d.rdata = {18'h0, q.welds};
        `OFS_STATUS: d.rdata = {30'h0, q.sts};
        `OFS_CLEAR: d.rdata = 32'h0000_0000;
        `OFS_IRQ_EN: d.rdata = {30'h0, q.ie};
        `OFS_HEAT_NOW: d.rdata = {25'h0, q.out_h};
        `OFS_CUR_NOW: d.rdata = {18'h0, q.out_c};
        default: begin
          if (tab_hit) begin
            case (tab_off[3:2])
              2'h0: d.rdata = {18'h0, q.scnt[tab_idx]};
              2'h1: d.rdata = {25'h0, q.sh[tab_idx]};
              default: d.rdata = {18'h0, q.sc[tab_idx]};
            endcase
          end else begin
            d.rdata = 32'h0000_0000;
            d.err = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_s) begin
    if (!rst_s) begin
      q <= '0;
      q.thr <= `DRESS_RESET;
      q.fin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = q.rdata;
  assign pslverr = q.err && psel && penable;
  assign first_weld_interval_heat = q.out_h;
  assign second_weld_interval_heat = q.out_h;
  assign first_weld_interval_current = q.out_c;
  assign second_weld_interval_current = q.out_c;
  assign dress_due_error = q.dress;
  assign step_end = q.fin;
  assign irq = |(q.sts & q.ie);

  // ==========================================================
  // Checks
  AST_INC: assert property (@(posedge mclk) disable iff (!rst_s)
    weld_done && !rst_req && q.welds < `WELD_MAX |=> q.welds == $past(q.welds) + 14'h0001)
    else $error("weld counter did not advance");
  AST_SAT: assert property (@(posedge mclk) disable iff (!rst_s)
    q.welds == `WELD_MAX && !rst_req |=> q.welds == `WELD_MAX)
    else $error("weld counter wrapped");
  AST_DRESS: assert property (@(posedge mclk) disable iff (!rst_s)
    dress_due_error == (q.welds == q.thr))
    else $error("dress error disagrees with count");
  AST_RST: assert property (@(posedge mclk) disable iff (!rst_s)
    rst_req |=> q.welds == 14'h0000 && q.n == 14'h0000)
    else $error("stepper reset did not clear");
  AST_DIS: assert property (@(posedge mclk) disable iff (!rst_s)
    !q.en |=> first_weld_interval_heat == 7'h00 && first_weld_interval_current == 14'h0000)
    else $error("increment applied while disabled");
  AST_CC: assert property (@(posedge mclk) disable iff (!rst_s)
    q.cc |=> second_weld_interval_heat == 7'h00)
    else $error("heat applied in constant current");
  AST_PS: assert property (@(posedge mclk) disable iff (!rst_s)
    !q.cc |=> second_weld_interval_current == 14'h0000)
    else $error("current applied in phase shift");
  AST_STEP: assert property (@(posedge mclk) disable iff (!rst_s)
    !q.fin |-> q.n < q.scnt[q.idx])
    else $error("step position beyond its count");
  AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_s)
    step_end && !rst_req |=> step_end && $stable(q.base_h) && $stable(q.base_c))
    else $error("final increment not held");
  AST_RANGE: assert property (@(posedge mclk) disable iff (!rst_s)
    q.heat <= `HEAT_MAX && q.cur <= `CUR_MAX)
    else $error("increment out of range");
  AST_END: assert property (@(posedge mclk) disable iff (!rst_s)
    $rose(step_end) |=> q.sts[`STS_STEP_END_BIT])
    else $error("step end not flagged");
  AST_DRESS_STS: assert property (@(posedge mclk) disable iff (!rst_s)
    $rose(dress_due_error) |-> q.sts[`STS_DRESS_BIT])
    else $error("dress reached but not flagged");
  AST_ADV: assert property (@(posedge mclk) disable iff (!rst_s)
    weld_done && !rst_req && q.en && !q.fin |=> q.n == $past(q.n) + 14'h0001 || q.n == 14'h0000)
    else $error("step position did not advance by one weld");
  AST_FROZEN: assert property (@(posedge mclk) disable iff (!rst_s)
    weld_done && !rst_req && !q.en |=> $stable(q.n) && $stable(q.idx))
    else $error("position moved while disabled");
  AST_UNUSED: assert property (@(posedge mclk) disable iff (!rst_s)
    !q.fin |-> q.scnt[q.idx] != 14'h0000)
    else $error("zero-count step in use");
  AST_BOTH: assert property (@(posedge mclk) disable iff (!rst_s)
    first_weld_interval_heat == second_weld_interval_heat &&
    first_weld_interval_current == second_weld_interval_current)
    else $error("weld intervals got different increments");
endmodule

//--- rtl/ramp_div.sv
// Serial restoring divider for the linear ramp fraction.
// Assumes den is never zero; one quotient bit per clock.
`timescale 1ns/10ps
module ramp_div #(
  parameter int NW = 28,
  parameter int DW = 14
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic [NW-1:0] quo,
  output logic busy,
  output logic done
);
  typedef struct packed {
    stepper_pkg::div_state_t st;
    logic [$clog2(NW)-1:0] cnt;
    logic [DW:0] rem;
    logic [NW-1:0] q;
    logic done;
  } div_reg_t;
  div_reg_t q, d;
  logic [DW:0] trial;

  always_comb begin
    d = q;
    d.done = 1'b0;
    trial = {q.rem[DW-1:0], q.q[NW-1]};
    case (q.st)
      stepper_pkg::DIV_IDLE: begin
        if (start) begin
          d.st = stepper_pkg::DIV_RUN;
          d.q = num;
          d.rem = '0;
          d.cnt = ($clog2(NW))'(NW - 1);
        end
      end
      stepper_pkg::DIV_RUN: begin
        if (trial >= {1'b0, den}) begin
          d.rem = trial - {1'b0, den};
          d.q = {q.q[NW-2:0], 1'b1};
        end else begin
          d.rem = trial;
          d.q = {q.q[NW-2:0], 1'b0};
        end
        if (q.cnt == '0) begin
          d.st = stepper_pkg::DIV_IDLE;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default: d.st = stepper_pkg::DIV_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign quo = q.q;
  assign busy = (q.st == stepper_pkg::DIV_RUN);
  assign done = q.done;
endmodule

//--- rtl/stepper_cfg.svh
// Constants of the electrode-wear stepper: register map, reset values, limits.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
`ifndef STEPPER_CFG_SVH
`define STEPPER_CFG_SVH
// ==========================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DRESS 8'h04
`define OFS_COUNT 8'h08
`define OFS_STATUS 8'h0C
`define OFS_CLEAR 8'h10
`define OFS_IRQ_EN 8'h14
`define OFS_HEAT_NOW 8'h18
`define OFS_CUR_NOW 8'h1C
`define OFS_STEP_BASE 8'h40
// ==========================================================
// Field positions
`define CTRL_EN_BIT 0
`define CTRL_CC_BIT 1
`define CTRL_RST_BIT 2
`define STS_DRESS_BIT 0
`define STS_STEP_END_BIT 1
// ==========================================================
// Limits and reset values
`define WELD_MAX 14'h270F
`define HEAT_MAX 7'h63
`define CUR_MAX 14'h270F
`define DRESS_RESET 14'h2328
`define NUM_STEPS 10
`endif

//--- rtl/stepper_pkg.sv
// Types shared by the stepper and its ramp divider.
// Assumes stepper_cfg.svh supplies all numeric constants.
package stepper_pkg;
  typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;
  typedef logic [13:0] count_t;
  typedef logic [6:0] heat_t;
endpackage

//--- verif/tb_electrode_wear_stepper.sv
// Bench for the electrode-wear stepper: APB set-up, ramps in both modes, dress, saturation.
// Assumes the register map and limits of stepper_cfg.svh.
`timescale 1ns/10ps
`include "stepper_cfg.svh"
module tb_electrode_wear_stepper;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic weld_done;
  logic fire = 1'b0;
  logic stepper_reset_in = 1'b0;
  logic [6:0] first_weld_interval_heat;
  logic [6:0] second_weld_interval_heat;
  logic [13:0] first_weld_interval_current;
  logic [13:0] second_weld_interval_current;
  logic dress_due_error;
  logic step_end;
  logic irq;
  logic [31:0] seed = 32'h98D09911;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  electrode_wear_stepper DUT (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .weld_done, .stepper_reset_in, .first_weld_interval_heat, .second_weld_interval_heat,
    .first_weld_interval_current, .second_weld_interval_current, .dress_due_error, .step_end, .irq);
  weld_sequencer seq (.mclk, .rst_n, .fire, .heat_in(first_weld_interval_heat),
    .cur_in(first_weld_interval_current), .weld_done, .used_q());

  // ==========================================================
  // Clock, timeout, report
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int ramp(int t0, int t1, int c0, int c1, int n);
    if (n <= c0) return t0 * n / c0;
    return t0 + (t1 - t0) * ((n - c0 > c1) ? c1 : n - c0) / c1;
  endfunction

  // ==========================================================
  // Bus and weld drivers
  // Waits on pready with no cap of its own; only the bench timeout ends a stuck transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  // Recompute takes about 33 cycles after the weld reaches the stepper
  task automatic weld();
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (36) @(posedge mclk);
  endtask

  task automatic outs(input int eh, input int ec);
    chk("heat first", eh, 32'(first_weld_interval_heat));
    chk("heat second", eh, 32'(second_weld_interval_heat));
    chk("current first", ec, 32'(first_weld_interval_current));
    chk("current second", ec, 32'(second_weld_interval_current));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int h0, h1, k0, k1, c0, c9, m, n;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc("dress reset", `OFS_DRESS, 32'h2328);
    rdc("count reset", `OFS_COUNT, 32'h0);
    chk("step_end idle", 32'h1, 32'(step_end));
    apb(1'b0, 8'h4C, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    h0 = xs() % 90;
    h1 = h0 + xs() % (100 - h0);
    k0 = xs() % 9000;
    k1 = k0 + xs() % (10000 - k0);
    c0 = 1 + xs() % 4;
    c9 = 1 + xs() % 3;
    wr(`OFS_STEP_BASE, c0);
    wr(`OFS_STEP_BASE + 8'h04, h0);
    wr(`OFS_STEP_BASE + 8'h08, k0);
    wr(`OFS_STEP_BASE + 8'h14, 32'h7F);
    rdc("heat clamp", `OFS_STEP_BASE + 8'h14, 32'h63);
    wr(`OFS_STEP_BASE + 8'h90, c9);
    wr(`OFS_STEP_BASE + 8'h94, h1);
    wr(`OFS_STEP_BASE + 8'h98, k1);
    for (m = 0; m < 2; m++) begin
      wr(`OFS_CTRL, 32'h5 | (m << 1));
      for (n = 0; n <= c0 + c9 + 1; n++) begin
        if (n > 0) weld();
        else repeat (36) @(posedge mclk);
        outs(m ? 0 : ramp(h0, h1, c0, c9, n), m ? ramp(k0, k1, c0, c9, n) : 0);
        chk("step_end", 32'(n >= c0 + c9), 32'(step_end));
      end
    end
    rdc("count", `OFS_COUNT, c0 + c9 + 1);
    wr(`OFS_CTRL, 32'h2);
    repeat (36) @(posedge mclk);
    outs(0, 0);
    wr(`OFS_CTRL, 32'h1);
    stepper_reset_in <= 1'b1;
    repeat (3) @(posedge mclk);
    stepper_reset_in <= 1'b0;
    repeat (36) @(posedge mclk);
    outs(0, 0);
    chk("step_end cleared", 32'h0, 32'(step_end));
    wr(`OFS_CTRL, 32'h4);
    rdc("count cleared", `OFS_COUNT, 32'h0);
    wr(`OFS_DRESS, 32'h3);
    wr(`OFS_IRQ_EN, 32'h0);
    repeat (3) weld();
    chk("dress error", 32'h1, 32'(dress_due_error));
    chk("irq masked", 32'h0, 32'(irq));
    wr(`OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(`OFS_CLEAR, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 32'h0, 32'(irq));
    weld();
    chk("dress left", 32'h0, 32'(dress_due_error));
    fire <= 1'b1;
    repeat (20010) @(posedge mclk);
    fire <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc("count saturated", `OFS_COUNT, 32'h270F);
    wr(`OFS_DRESS, 32'hFFFF);
    rdc("dress clamp", `OFS_DRESS, 32'h270F);
    repeat (2) @(posedge mclk);
    chk("dress at max", 32'h1, 32'(dress_due_error));
    stop_test();
  end
endmodule

//--- verif/weld_sequencer.sv
// Stand-in for the weld-schedule sequencer: delivers welds, takes the offsets.
// Assumes fire comes from the bench in the mclk domain.
`timescale 1ns/10ps
module weld_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [6:0] heat_in,
  input wire logic [13:0] cur_in,
  output logic weld_done,
  output logic [20:0] used_q
);
  // ==========================================================
  // Weld delivery
  // A held fire gives one weld every second cycle, never a stuck pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      weld_done <= 1'b0;
      used_q <= '0;
    end else begin
      weld_done <= fire & ~weld_done;
      if (weld_done) begin
        used_q <= {heat_in, cur_in};
      end
    end
  end
endmodule
